// >>> pkg/dtcm_pkg.sv
// Purpose: shared constants and types for the dual timer / capture block
// Assumes: one clock domain, plain control ports, no register bus
// Notes: counters and reload registers are sixteen bits wide
`default_nettype none

package dtcm_pkg;

    // data path width
    localparam int CNT_W = 16;

    // counter values with a fixed meaning
    localparam logic [15:0] CNT_PRESET = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // reset values of the control state
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_CR = 16'h0000;
    localparam logic [3:0] RST_PEND = 4'h0;
    localparam logic RST_LEVEL = 1'b0;

    // bit positions inside the four-bit pending and enable vectors
    localparam int PND_A = 0;
    localparam int PND_B = 1;
    localparam int PND_C = 2;
    localparam int PND_D = 3;

    // operating modes
    typedef enum logic [2:0] {
        DTCM_MODE1 = 3'h0,
        DTCM_MODE1A = 3'h1,
        DTCM_MODE2 = 3'h2,
        DTCM_MODE3 = 3'h3,
        DTCM_MODE4 = 3'h4
    } dtcm_mode_t;

    // clock source of one counter
    typedef enum logic [1:0] {
        DTCM_CLK_NONE = 2'h0,
        DTCM_CLK_PRESC = 2'h1,
        DTCM_CLK_EVENT = 2'h2,
        DTCM_CLK_ACCUM = 2'h3
    } dtcm_clk_t;

endpackage : dtcm_pkg

`default_nettype wire

// >>> design/dtcm_timer.sv
// Purpose: two 16-bit down-counters with two capture/reload registers
// Assumes: all inputs synchronous to i_clk_sys; prescaler gives a one-cycle tick
// Notes: modes 1, 1a, 2, 3 and 4; pending flags cleared by a separate clear vector
//
// Contract
// [RL1] mode 3: counter one reloads from A
// [RL2] pin A toggles per counter-one underflow
// [RL3] mode 3: counter-one underflow sets pending A
// [RL4] mode 3: counter two reloads from B
// [RL5] mode 3: counter-two underflow sets pending D
// [RL6] mode 3: either counter clocked by pin B
// [RL7] mode 4: counter one reloads, toggles, sets A
// [RL8] mode 4: pin B edge captures counter two
// [RL9] mode 4 with pin-B enable: capture then preset
// [RL10] mode 4: counter-two underflow sets pending D
// [RL11] pin-B edge bit selects rising or falling
// [RL12] capture pulses last one clock at least
// [RL13] mode 4: counter two stops on pin-B clock
// [RL14] pin A driven from output-level bit
// [RL15] pin A enable clear: no toggle; mode 2 captures
// [RL16] pin B enable clear: event input or capture
// [RL17] four sources; A,B,C to irq A, D to B
// [RL18] C only mode 2; B unused mode 3
// [RL19] modes 1/1a: reloads from A/B set flags
// [RL20] separate clear input for pending flags
// [RL21] reload register writes ignored while disabled
// [RL22] decrement per tick; wrap below zero underflows
// [RL23] irq outputs follow enabled pending flags
`default_nettype none

module dtcm_timer
    import dtcm_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // configuration
    input wire logic i_timer_enable,
    input wire logic [2:0] i_mode,
    input wire logic [1:0] i_clk1_sel,
    input wire logic [1:0] i_clk2_sel,
    input wire logic i_presc_tick,
    input wire logic i_pin_a_en,
    input wire logic i_pin_b_en,
    input wire logic i_pin_a_edge,
    input wire logic i_pin_b_edge,
    input wire logic i_pulse_train_sw_sel,
    input wire logic i_pulse_train_sw_start,
    // software writes
    input wire logic [15:0] i_wdata,
    input wire logic i_cnt1_wr,
    input wire logic i_cnt2_wr,
    input wire logic i_cra_wr,
    input wire logic i_crb_wr,
    input wire logic i_level_wr,
    // interrupt control
    input wire logic [3:0] i_irq_enable,
    input wire logic [3:0] i_pend_clr,
    // pins
    input wire logic i_pin_a,
    input wire logic i_pin_b,
    output logic o_pin_a,
    output logic o_pin_a_oe_n,
    // status
    output logic [15:0] o_cnt1,
    output logic [15:0] o_cnt2,
    output logic [15:0] o_cra,
    output logic [15:0] o_crb,
    output logic [3:0] o_pend,
    output logic o_irq_a,
    output logic o_irq_b
);

    // state
    logic [15:0] cnt1_q, cnt1_d;
    logic [15:0] cnt2_q, cnt2_d;
    logic [15:0] cra_q, cra_d;
    logic [15:0] crb_q, crb_d;
    logic [3:0] pend_q, pend_d;
    logic level_q, level_d;
    logic oe_n_q;
    logic irq_a_q, irq_b_q;
    logic pin_a_prev_q, pin_b_prev_q;
    logic use_b_q, use_b_d;
    logic train_q, train_d;

    // mode decode
    dtcm_mode_t mode;
    dtcm_clk_t sel1, sel2;
    wire logic m1 = (mode == DTCM_MODE1);
    wire logic m1a = (mode == DTCM_MODE1A);
    wire logic m2 = (mode == DTCM_MODE2);
    wire logic m3 = (mode == DTCM_MODE3);
    wire logic m4 = (mode == DTCM_MODE4);
    wire logic pwm_mode = m1 | m1a;
    assign mode = dtcm_mode_t'(i_mode);
    assign sel1 = dtcm_clk_t'(i_clk1_sel);
    assign sel2 = dtcm_clk_t'(i_clk2_sel);

    // edge detection; a pulse shorter than one clock may be missed entirely
    wire logic a_rise = i_pin_a & ~pin_a_prev_q;
    wire logic a_fall = ~i_pin_a & pin_a_prev_q;
    wire logic b_rise = i_pin_b & ~pin_b_prev_q;
    wire logic b_fall = ~i_pin_b & pin_b_prev_q;
    wire logic a_edge = i_timer_enable & (i_pin_a_edge ? a_rise : a_fall);
    wire logic b_edge = i_timer_enable & (i_pin_b_edge ? b_rise : b_fall); // RL11 RL12

    // pin B as a clock: one tick per selected edge, or prescaled ticks while high
    wire logic b_event_tick = b_edge; // RL6 RL16
    wire logic b_accum_tick = i_presc_tick & i_pin_b;

    // counter one tick; pin B is a capture input in mode 2 so the pin-B clocks stop there
    logic tick1_raw;
    always_comb begin
        case (sel1)
            DTCM_CLK_PRESC: tick1_raw = i_presc_tick;
            DTCM_CLK_EVENT: tick1_raw = b_event_tick & ~m2;
            DTCM_CLK_ACCUM: tick1_raw = b_accum_tick & ~m2;
            DTCM_CLK_NONE: tick1_raw = 1'b0;
            default: tick1_raw = 1'b0;
        endcase
    end
    wire logic tick1 = i_timer_enable & tick1_raw & (~m1a | train_q);

    // counter one underflow: tick while at zero
    wire logic unf1 = tick1 & (cnt1_q == CNT_ZERO); // RL22

    // counter two tick; in mode 1a it counts underflows of counter one instead
    logic tick2_raw;
    always_comb begin
        case (sel2)
            DTCM_CLK_PRESC: tick2_raw = i_presc_tick;
            DTCM_CLK_EVENT: tick2_raw = b_event_tick & ~m4; // RL13
            DTCM_CLK_ACCUM: tick2_raw = b_accum_tick & ~m4; // RL13
            DTCM_CLK_NONE: tick2_raw = 1'b0;
            default: tick2_raw = 1'b0;
        endcase
    end
    wire logic tick2 = i_timer_enable & (m1a ? unf1 : tick2_raw);
    wire logic unf2 = tick2 & (cnt2_q == CNT_ZERO); // RL22

    // capture events
    wire logic cap_a2 = m2 & a_edge; // RL15
    wire logic cap_b2 = m2 & b_edge;
    wire logic cap_b4 = m4 & b_edge; // RL8
    wire logic preset1 = (cap_a2 & i_pin_a_en) | (cap_b2 & i_pin_b_en);
    wire logic preset2 = cap_b4 & i_pin_b_en; // RL9

    // pulse train start and stop
    wire logic train_go = i_pulse_train_sw_sel ? i_pulse_train_sw_start : b_edge; // RL16
    always_comb begin
        train_d = train_q;
        if (!m1a || !i_timer_enable) begin
            train_d = 1'b0;
        end else if (unf2) begin
            train_d = 1'b0;
        end else if (train_go) begin
            train_d = 1'b1;
        end
    end

    // counter one next value; alternating reload only in modes 1 and 1a
    wire logic [15:0] reload1 = (pwm_mode && use_b_q) ? crb_q : cra_q;
    always_comb begin
        cnt1_d = cnt1_q;
        use_b_d = use_b_q;
        if (!pwm_mode || (sel1 == DTCM_CLK_NONE)) begin
            use_b_d = 1'b0;
        end
        if (i_cnt1_wr) begin
            cnt1_d = i_wdata;
        end else if (preset1) begin
            cnt1_d = CNT_PRESET; // RL9
        end else if (unf1 && (m1 || m1a || m3 || m4)) begin
            cnt1_d = reload1; // RL1 RL7
            use_b_d = pwm_mode & ~use_b_q;
        end else if (tick1) begin
            cnt1_d = cnt1_q - CNT_ONE; // RL22
        end
    end

    // counter two next value
    always_comb begin
        cnt2_d = cnt2_q;
        if (i_cnt2_wr) begin
            cnt2_d = i_wdata;
        end else if (preset2) begin
            cnt2_d = CNT_PRESET; // RL9
        end else if (unf2 && m3) begin
            cnt2_d = crb_q; // RL4
        end else if (unf2 && m1a) begin
            cnt2_d = CNT_ZERO;
        end else if (tick2) begin
            cnt2_d = cnt2_q - CNT_ONE; // RL22
        end
    end

    // capture/reload registers; writes only land while the timer is on
    always_comb begin
        cra_d = cra_q;
        crb_d = crb_q;
        if (cap_a2) begin
            cra_d = cnt1_q; // RL15
        end else if (i_cra_wr && i_timer_enable) begin
            cra_d = i_wdata; // RL21
        end
        if (cap_b2) begin
            crb_d = cnt1_q; // RL16
        end else if (cap_b4) begin
            crb_d = cnt2_q; // RL8 RL16
        end else if (i_crb_wr && i_timer_enable) begin
            crb_d = i_wdata; // RL21
        end
    end

    // pending flag sources per mode
    wire logic reload_a1 = pwm_mode & unf1 & ~use_b_q;
    wire logic reload_b1 = pwm_mode & unf1 & use_b_q;
    wire logic set_a = reload_a1 | cap_a2 | ((m3 | m4) & unf1); // RL3 RL7 RL19
    wire logic set_b = reload_b1 | cap_b2 | cap_b4; // RL8 RL18 RL19
    wire logic set_c = m2 & unf1; // RL18
    wire logic set_d = unf2; // RL5 RL10 RL18
    wire logic [3:0] pend_set = {set_d, set_c, set_b, set_a};

    // a set arriving with its clear wins so no event is lost
    assign pend_d = (pend_q & ~i_pend_clr) | pend_set; // RL20 RL17

    // pin A level: software load, then toggle per underflow if enabled and not in mode 2
    wire logic toggle_a = unf1 & i_pin_a_en & ~m2; // RL2 RL15
    always_comb begin
        level_d = level_q;
        if (i_level_wr) begin
            level_d = i_wdata[0]; // RL14
        end else if (toggle_a) begin
            level_d = ~level_q; // RL2
        end
    end

    // interrupt lines, registered from the next flag state
    wire logic irq_a_d = |(pend_d[PND_C:PND_A] & i_irq_enable[PND_C:PND_A]); // RL17 RL23
    wire logic irq_b_d = pend_d[PND_D] & i_irq_enable[PND_D]; // RL17 RL23

    // state registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cnt1_q <= RST_CNT;
            cnt2_q <= RST_CNT;
            cra_q <= RST_CR;
            crb_q <= RST_CR;
            pend_q <= RST_PEND;
            level_q <= RST_LEVEL;
            use_b_q <= 1'b0;
            train_q <= 1'b0;
        end else begin
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
            cra_q <= cra_d;
            crb_q <= crb_d;
            pend_q <= pend_d;
            level_q <= level_d;
            use_b_q <= use_b_d;
            train_q <= train_d;
        end
    end

    // pin history and output-side registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pin_a_prev_q <= i_pin_a; // take the idle level so no false edge follows reset
            pin_b_prev_q <= i_pin_b;
            oe_n_q <= 1'b1;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            pin_a_prev_q <= i_pin_a;
            pin_b_prev_q <= i_pin_b;
            oe_n_q <= m2; // pin A is an input only in mode 2
            irq_a_q <= irq_a_d;
            irq_b_q <= irq_b_d;
        end
    end

    // outputs straight from flip-flops
    assign o_pin_a = level_q; // RL14
    assign o_pin_a_oe_n = oe_n_q;
    assign o_cnt1 = cnt1_q;
    assign o_cnt2 = cnt2_q;
    assign o_cra = cra_q;
    assign o_crb = crb_q;
    assign o_pend = pend_q;
    assign o_irq_a = irq_a_q;
    assign o_irq_b = irq_b_q;

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence s_unf1_m3;
        m3 && unf1 && !i_cnt1_wr && !preset1;
    endsequence

    sequence s_cap4;
        cap_b4 && !i_cnt2_wr;
    endsequence

    mode3_reload_a : assert property (s_unf1_m3 |=> cnt1_q == $past(cra_q)) // RL1
        else $error("counter one did not reload from A in mode 3");
    pin_toggle_a : assert property (toggle_a && !i_level_wr |=> o_pin_a != $past(o_pin_a)) // RL2
        else $error("pin A did not toggle on underflow");
    no_toggle_a : assert property (!i_pin_a_en && !i_level_wr |=> $stable(o_pin_a)) // RL15
        else $error("pin A moved with its enable clear");
    flag_a_set_a : assert property (s_unf1_m3 |=> o_pend[PND_A]) // RL3
        else $error("pending A not set on mode 3 underflow");
    mode3_reload_b_a : assert property (m3 && unf2 && !i_cnt2_wr |=> cnt2_q == $past(crb_q) && o_pend[PND_D]) // RL4
        else $error("counter two did not reload from B in mode 3");
    capture_preset_a : assert property ((s_cap4 and i_pin_b_en) // RL9
        |=> crb_q == $past(cnt2_q) ##0 cnt2_q == CNT_PRESET)
        else $error("capture then preset failed in mode 4");
    capture_plain_a : assert property ((s_cap4 and (!i_pin_b_en && !tick2)) // RL8
        |=> cnt2_q == $past(cnt2_q) && o_pend[PND_B])
        else $error("plain capture altered counter two");
    mode2_capture_a : assert property (cap_a2 && !i_pin_a_en |=> cra_q == $past(cnt1_q) && o_pend[PND_A]) // RL15
        else $error("pin A capture failed in mode 2");
    alt_reload_b_a : assert property (reload_b1 && !i_cnt1_wr |=> cnt1_q == $past(crb_q) && o_pend[PND_B]) // RL19
        else $error("counter one did not reload from B");
    count_down_a : assert property (tick1 && !unf1 && !i_cnt1_wr && !preset1 // RL22
        |=> cnt1_q == $past(cnt1_q) - CNT_ONE)
        else $error("counter one did not step down by one");
    flag_d_set_a : assert property (unf2 |=> o_pend[PND_D]) // RL10 RL5
        else $error("pending D not set on counter two underflow");
    stop_cnt2_a : assert property (m4 && sel2 == DTCM_CLK_EVENT && !i_cnt2_wr && !preset2 |=> $stable(cnt2_q)) // RL13
        else $error("counter two ran on pin B clock in mode 4");
    cr_write_off_a : assert property (!i_timer_enable && !cap_a2 |=> $stable(cra_q)) // RL21
        else $error("reload A written while disabled");
    flag_c_mode_a : assert property (!m2 && !pend_q[PND_C] |=> !o_pend[PND_C]) // RL18
        else $error("pending C set outside mode 2");
    flag_b_m3_a : assert property (m3 && !pend_q[PND_B] |=> !o_pend[PND_B]) // RL18
        else $error("pending B set in mode 3");
    irq_follow_a : assert property (o_pend[PND_D] && i_irq_enable[PND_D] && !i_pend_clr[PND_D] |=> o_irq_b) // RL23 RL17
        else $error("irq B not raised by enabled pending D");
    clear_flag_a : assert property (i_pend_clr[PND_A] && !set_a |=> !o_pend[PND_A]) // RL20
        else $error("pending A not cleared");

endmodule : dtcm_timer

`default_nettype wire

// >>> bench/dtcm_pin_model.sv
// Purpose: external signal source on pin B for the dual timer block
// Assumes: one clock; the bench asks for each pulse
// Notes: a pulse is never shorter than one clock
`default_nettype none

module dtcm_pin_model (
    // clock and request
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [3:0] i_width,
    // pin
    output logic o_pin_b
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] left_q = 4'h0;
    logic pin_q = 1'b0;

    // pulse generator; width 0 is stretched, a shorter pulse would be missed
    always @(posedge i_clk_sys) begin
        if (i_go) begin
            pin_q <= 1'b1;
            left_q <= (i_width == 4'h0) ? 4'h1 : i_width;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
                pin_q <= 1'b0;
            end
        end
    end
    assign o_pin_b = pin_q;
endmodule : dtcm_pin_model

`default_nettype wire

// >>> bench/dual_timer_capture_modes_tb.sv
// Purpose: self-checking bench for the dual timer / capture block
// Assumes: prescaler ticks are made by the bench, one cycle each
// Notes: disable case, mode 3 table run, then capture, clear, reset and mode 1 cases
`default_nettype none

module dual_timer_capture_modes_tb;
    import dtcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0, rstn = 1'b0, en = 1'b0, tick = 1'b0, aen = 1'b0, ben = 1'b0, bedg = 1'b0, go = 1'b0;
    logic aedg = 1'b0, pa_in = 1'b1;
    logic [2:0] mode = 3'h0;
    logic [1:0] sel1 = 2'h0, sel2 = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [4:0] wr_v = 5'h00;
    logic [3:0] ien = 4'h0, clr = 4'h0;
    logic pin_b, pin_a, oe_n, irq_a, irq_b, pin_a_wire;
    logic [15:0] cnt1, cnt2, cra, crb;
    logic [3:0] pend;
    int bad_count = 0, n_compared = 0;
    // mode 3 rows per tick: counter one, counter two, pin A
    localparam logic [32:0] ROWS [5] = '{{16'h0003, 16'h0002, 1'b0}, {16'h0002, 16'h0001, 1'b0},
        {16'h0001, 16'h0000, 1'b0}, {16'h0000, 16'h0002, 1'b0}, {16'h0003, 16'h0001, 1'b1}};

    always #10 clk = ~clk;
    // pin A is pulled high outside; pa_in pulls it low once the block releases it
    assign pin_a_wire = oe_n ? pa_in : pin_a;

    dtcm_timer dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_timer_enable(en), .i_mode(mode),
        .i_clk1_sel(sel1), .i_clk2_sel(sel2), .i_presc_tick(tick), .i_pin_a_en(aen), .i_pin_b_en(ben),
        .i_pin_a_edge(aedg), .i_pin_b_edge(bedg), .i_pulse_train_sw_sel(1'b0), .i_pulse_train_sw_start(1'b0),
        .i_wdata(wdata), .i_cnt1_wr(wr_v[0]), .i_cnt2_wr(wr_v[1]), .i_cra_wr(wr_v[2]), .i_crb_wr(wr_v[3]),
        .i_level_wr(wr_v[4]), .i_irq_enable(ien), .i_pend_clr(clr), .i_pin_a(pin_a_wire), .i_pin_b(pin_b),
        .o_pin_a(pin_a), .o_pin_a_oe_n(oe_n), .o_cnt1(cnt1), .o_cnt2(cnt2), .o_cra(cra), .o_crb(crb),
        .o_pend(pend), .o_irq_a(irq_a), .o_irq_b(irq_b));
    dtcm_pin_model pins_u (.i_clk_sys(clk), .i_go(go), .i_width(4'h2), .o_pin_b(pin_b));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle write strobe; 0 cnt1, 1 cnt2, 2 cra, 3 crb, 4 level
    task automatic wr(input int idx, input logic [15:0] d);
        @(posedge clk);
        wdata <= d;
        wr_v <= 5'h01 << idx;
        @(posedge clk);
        wr_v <= 5'h00;
    endtask : wr
    task automatic tick1();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
    endtask : tick1
    // pulse on pin B, then time for both of its edges to land
    task automatic pulse();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : pulse
    task automatic clear(input logic [3:0] m);
        @(posedge clk);
        clr <= m;
        @(posedge clk);
        clr <= 4'h0;
        @(negedge clk);
    endtask : clear
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(cnt1, RST_CNT);
        chk({12'h000, pend}, 16'h0000);
        chk({15'h0000, oe_n}, 16'h0001);
        // reload write while disabled must not land
        wr(2, 16'h1234);
        @(negedge clk);
        chk(cra, RST_CR);
        @(posedge clk);
        en <= 1'b1;
        mode <= DTCM_MODE3;
        sel1 <= DTCM_CLK_PRESC;
        sel2 <= DTCM_CLK_PRESC;
        aen <= 1'b1;
        wr(4, 16'h0001);
        wr(2, 16'h0003);
        wr(3, 16'h0002);
        @(negedge clk);
        chk({15'h0000, pin_a}, 16'h0001);
        chk({15'h0000, oe_n}, 16'h0000);
        // table walk: reloads, toggles, underflow at zero
        for (int i = 0; i < 5; i++) begin
            tick1();
            chk(cnt1, ROWS[i][32:17]);
            chk(cnt2, ROWS[i][16:1]);
            chk({15'h0000, pin_a}, {15'h0000, ROWS[i][0]});
        end
        chk({12'h000, pend}, 16'h0009);
        chk({14'h0000, irq_a, irq_b}, 16'h0000);
        @(posedge clk);
        ien <= 4'hF;
        repeat (2) @(negedge clk);
        chk({14'h0000, irq_a, irq_b}, 16'h0003);
        clear(4'h9);
        chk({8'h00, pend, 2'h0, irq_a, irq_b}, 16'h0000);
        // mode 4 capture with preset on the rising edge only
        @(posedge clk);
        mode <= DTCM_MODE4;
        ben <= 1'b1;
        bedg <= 1'b1;
        wr(1, 16'h0050);
        pulse();
        chk(crb, 16'h0050);
        chk(cnt2, CNT_PRESET);
        chk({12'h000, pend}, 16'h0002);
        chk({15'h0000, irq_a}, 16'h0001);
        // falling edge, no preset
        @(posedge clk);
        bedg <= 1'b0;
        ben <= 1'b0;
        wr(1, 16'h0011);
        pulse();
        chk(crb, 16'h0011);
        chk(cnt2, 16'h0011);
        clear(4'hF);
        wr(1, 16'h0000);
        tick1();
        chk({12'h000, pend}, 16'h0008);
        chk(cnt1, 16'h0002);
        chk({15'h0000, irq_b}, 16'h0001);
        // pin-B clock stops counter two in mode 4 but still drives counter one
        @(posedge clk);
        sel1 <= DTCM_CLK_EVENT;
        sel2 <= DTCM_CLK_EVENT;
        wr(1, 16'h0005);
        pulse();
        chk(cnt1, 16'h0001);
        tick1();
        chk(cnt2, 16'h0005);
        chk(cnt1, 16'h0001);
        // mode 2: falling edge on pin A captures counter one, no preset
        @(posedge clk);
        mode <= DTCM_MODE2;
        aen <= 1'b0;
        sel1 <= DTCM_CLK_PRESC;
        clear(4'hF);
        @(posedge clk);
        pa_in <= 1'b0;
        repeat (2) @(negedge clk);
        chk(cra, 16'h0001);
        chk({12'h000, pend}, 16'h0001);
        tick1();
        tick1();
        chk(cnt1, CNT_PRESET);
        chk({12'h000, pend}, 16'h0005);
        // reset in mid-run clears state and releases pin A
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(cnt1, RST_CNT);
        chk({11'h000, oe_n, pend}, 16'h0010);
        chk({14'h0000, irq_a, irq_b}, 16'h0000);
        // mode 1: reloads alternate A then B, each with its own flag
        @(posedge clk);
        mode <= DTCM_MODE1;
        wr(2, 16'h0001);
        wr(3, 16'h0002);
        tick1();
        chk(cnt1, 16'h0001);
        chk({12'h000, pend}, 16'h0001);
        tick1();
        tick1();
        chk(cnt1, 16'h0002);
        chk({12'h000, pend}, 16'h0003);
        end_sim();
    end
endmodule : dual_timer_capture_modes_tb

`default_nettype wire
